// File: logic/abp_pkg.sv
package abp_pkg;

  // ****************************************************************
  // special-function bus page and address decode
  // ****************************************************************
  localparam logic [7:0] PAGE_CONFIG = 8'h00;
  localparam logic [7:0] PAGE_POWER = 8'h0f;
  localparam logic [7:0] ADDR_SHARED = 8'hba;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbe;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ****************************************************************
  // accumulator_config field layout and reset
  // ****************************************************************
  localparam int AC_TWELVE_BIT = 7;
  localparam int AC_ACCUMULATE = 6;
  localparam int AC_FORMAT_HI = 5;
  localparam int AC_FORMAT_LO = 3;
  localparam int AC_REPEAT_HI = 2;
  localparam int AC_REPEAT_LO = 0;
  localparam logic [7:0] AC_RESET = 8'h00;

  // ****************************************************************
  // burst_powerup_time field layout and reset
  // ****************************************************************
  localparam int PW_LOW_POWER = 7;
  localparam int PW_DELAY_HI = 3;
  localparam int PW_DELAY_LO = 0;
  localparam logic [7:0] PW_RESET = 8'h0f;
  localparam logic [2:0] PW_UNUSED_READ = 3'h0;

  // ****************************************************************
  // format and repeat encodings
  // ****************************************************************
  localparam logic [2:0] FMT_RIGHT_0 = 3'h0;
  localparam logic [2:0] FMT_RIGHT_1 = 3'h1;
  localparam logic [2:0] FMT_RIGHT_2 = 3'h2;
  localparam logic [2:0] FMT_RIGHT_3 = 3'h3;
  localparam logic [2:0] FMT_LEFT = 3'h4;
  localparam logic [2:0] RPT_1 = 3'h0;
  localparam logic [2:0] RPT_4 = 3'h1;
  localparam logic [2:0] RPT_8 = 3'h2;
  localparam logic [2:0] RPT_16 = 3'h3;
  localparam logic [2:0] RPT_32 = 3'h4;
  localparam logic [2:0] RPT_64 = 3'h5;
  localparam int RESOLUTION_12 = 12;
  localparam int RESOLUTION_10 = 10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_UNIT_NS = 400;
  localparam int POWERUP_UNIT_CYCLES =
    (POWERUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } abp_sfr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } abp_result_t;

endpackage

// File: logic/abp_powerup_timer.sv
`timescale 1ns/1ns
// counts (units + 1) ticks of the 400 ns enable, then one done pulse
module abp_powerup_timer #(
  parameter int UNIT_CYCLES = abp_pkg::POWERUP_UNIT_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [3:0] units_i,
  output logic done_o
);

  logic [7:0] prescale;
  logic [3:0] remaining;
  logic running;
  logic tick;

  // one-cycle enable every unit while running
  assign tick = running && (prescale == 8'(UNIT_CYCLES - 1));

  // prescaler restarts with every start so the first unit is whole
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || start_i || tick) begin
      prescale <= 8'h00;
    end else if (running) begin
      prescale <= prescale + 8'h01;
    end
  end

  // unit countdown
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      running <= 1'b0;
      remaining <= 4'h0;
    end else if (start_i) begin
      running <= 1'b1;
      remaining <= units_i;
    end else if (tick) begin
      if (remaining == 4'h0) begin
        running <= 1'b0;
      end else begin
        remaining <= remaining - 4'h1;
      end
    end
  end

  // done pulse registered on the final tick
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= tick && (remaining == 4'h0) && !start_i;
    end
  end

endmodule

// File: logic/abp_readback_format.sv
`timescale 1ns/1ns
// shapes the raw accumulator into the readback word
module abp_readback_format (
  input wire logic [15:0] acc_i,
  input wire logic [2:0] format_i,
  input wire logic twelve_bit_i,
  output logic [15:0] word_o
);

  // right shifts pull high-byte bits into the low byte and
  // fill the top with zeros; reserved codes read unshifted
  always_comb begin
    word_o = acc_i;
    case (format_i)
      abp_pkg::FMT_RIGHT_1: word_o = acc_i >> 1; // R7 R19
      abp_pkg::FMT_RIGHT_2: word_o = acc_i >> 2; // R7 R19
      abp_pkg::FMT_RIGHT_3: word_o = acc_i >> 3; // R7 R19
      abp_pkg::FMT_LEFT: begin
        if (twelve_bit_i) begin
          word_o = acc_i << ($bits(acc_i) - abp_pkg::RESOLUTION_12); // R8
        end else begin
          word_o = acc_i << ($bits(acc_i) - abp_pkg::RESOLUTION_10); // R8
        end
      end
      default: word_o = acc_i; // R7
    endcase
  end

endmodule

// File: logic/abp_core.sv
`timescale 1ns/1ns
// What this block does
// [R1] shared address decoded by page zero and fifteen
// [R2] config bit seven enables twelve-bit mode
// [R3] no burst, no accumulate: latest result only
// [R4] no burst, accumulate: results add into result
// [R5] software clears total by writing zero bytes
// [R6] accumulate bit is write-only, reads zero
// [R7] codes zero to three right-shift readback
// [R8] code four left-justifies; other codes reserved
// [R9] burst repeat codes give 1..64 conversions
// [R10] software sets repeat zero outside burst
// [R11] power register bit seven enables low power
// [R12] power bits six to four read zero
// [R13] outside burst, power follows converter enable
// [R14] burst with enable: stay powered, start immediately
// [R15] burst without enable: power-up delay, then sleep
// [R16] delay is field plus one times 400 ns
// [R17] field value four suggested for tracking
// [R18] reset values zero and low nibble ones
// [R19] shifted readback drags high bits down
// [R20] no track delay before first burst conversion
// [R21] accumulator sixteen bits, wraps, no flag
module abp_core #(
  parameter int UNIT_CYCLES = abp_pkg::POWERUP_UNIT_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire abp_pkg::abp_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic burst_mode_enable_i,
  input wire logic converter_enable_i,
  input wire logic soc_i,
  input wire abp_pkg::abp_result_t conv_result_i,
  output logic twelve_bit_enable_o,
  output logic converter_low_power_enable_o,
  output logic converter_power_on_o,
  output logic convert_start_o,
  output logic first_conversion_o,
  output logic burst_busy_o
);

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_POWERUP,
    ST_START,
    ST_WAIT
  } abp_state_t;

  abp_state_t state;
  logic twelve_bit_enable;
  logic accumulate_enable;
  logic [2:0] shift_justify_format;
  logic [2:0] burst_repeat_count;
  logic converter_low_power_enable;
  logic [3:0] powerup_delay_field;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [15:0] readback;
  logic [6:0] conv_left;
  logic [6:0] repeat_total;
  logic burst_first_result;
  logic timer_start;
  logic timer_done;
  logic sel_config;
  logic sel_power;
  logic sel_low;
  logic sel_high;
  logic burst_go;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one address, two registers: the page picks which
  // result bytes only live on page zero; other pages read zero
  always_comb begin
    sel_config = 1'b0;
    sel_power = 1'b0;
    sel_low = 1'b0;
    sel_high = 1'b0;
    if (sfr_req_i.page == abp_pkg::PAGE_CONFIG &&
        sfr_req_i.addr == abp_pkg::ADDR_SHARED) begin
      sel_config = 1'b1; // R1
    end else if (sfr_req_i.page == abp_pkg::PAGE_POWER &&
                 sfr_req_i.addr == abp_pkg::ADDR_SHARED) begin
      sel_power = 1'b1; // R1
    end else if (sfr_req_i.page == abp_pkg::PAGE_CONFIG &&
                 sfr_req_i.addr == abp_pkg::ADDR_RESULT_LOW) begin
      sel_low = 1'b1;
    end else if (sfr_req_i.page == abp_pkg::PAGE_CONFIG &&
                 sfr_req_i.addr == abp_pkg::ADDR_RESULT_HIGH) begin
      sel_high = 1'b1;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // accumulator_config fields
  // accumulate bit kept for the data path, never read back
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      twelve_bit_enable <= abp_pkg::AC_RESET[abp_pkg::AC_TWELVE_BIT]; // R18
      accumulate_enable <= abp_pkg::AC_RESET[abp_pkg::AC_ACCUMULATE];
      shift_justify_format <=
        abp_pkg::AC_RESET[abp_pkg::AC_FORMAT_HI:abp_pkg::AC_FORMAT_LO];
      burst_repeat_count <=
        abp_pkg::AC_RESET[abp_pkg::AC_REPEAT_HI:abp_pkg::AC_REPEAT_LO];
    end else if (sfr_req_i.wr && sel_config) begin
      twelve_bit_enable <= sfr_req_i.wdata[abp_pkg::AC_TWELVE_BIT]; // R2
      accumulate_enable <= sfr_req_i.wdata[abp_pkg::AC_ACCUMULATE];
      shift_justify_format <=
        sfr_req_i.wdata[abp_pkg::AC_FORMAT_HI:abp_pkg::AC_FORMAT_LO];
      burst_repeat_count <=
        sfr_req_i.wdata[abp_pkg::AC_REPEAT_HI:abp_pkg::AC_REPEAT_LO];
    end
  end

  // burst_powerup_time fields; bits six to four are not stored
  // no storage there, so writes to them cannot stick
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      converter_low_power_enable <=
        abp_pkg::PW_RESET[abp_pkg::PW_LOW_POWER]; // R18
      powerup_delay_field <=
        abp_pkg::PW_RESET[abp_pkg::PW_DELAY_HI:abp_pkg::PW_DELAY_LO];
    end else if (sfr_req_i.wr && sel_power) begin
      converter_low_power_enable <=
        sfr_req_i.wdata[abp_pkg::PW_LOW_POWER]; // R11
      powerup_delay_field <=
        sfr_req_i.wdata[abp_pkg::PW_DELAY_HI:abp_pkg::PW_DELAY_LO]; // R12
    end
  end

  assign twelve_bit_enable_o = twelve_bit_enable; // R2
  assign converter_low_power_enable_o = converter_low_power_enable; // R11

  // ****************************************************************
  // register readback
  // ****************************************************************
  abp_readback_format u_format (
    .acc_i(acc),
    .format_i(shift_justify_format),
    .twelve_bit_i(twelve_bit_enable),
    .word_o(readback)
  );

  // read data held until the next read strobe
  // reading never disturbs the total; the two bytes are taken
  // independently, so software should read them back to back
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= abp_pkg::READ_UNMAPPED;
    end else if (sfr_req_i.rd) begin
      if (sel_config) begin
        sfr_rdata_o <= {twelve_bit_enable, 1'b0, // R6
                        shift_justify_format, burst_repeat_count};
      end else if (sel_power) begin
        sfr_rdata_o <= {converter_low_power_enable,
                        abp_pkg::PW_UNUSED_READ, // R12
                        powerup_delay_field};
      end else if (sel_low) begin
        sfr_rdata_o <= readback[7:0]; // R19
      end else if (sel_high) begin
        sfr_rdata_o <= readback[15:8]; // R19
      end else begin
        sfr_rdata_o <= abp_pkg::READ_UNMAPPED;
      end
    end
  end

  // ****************************************************************
  // accumulator
  // ****************************************************************
  // replace or add; the add is cut to sixteen bits and simply wraps
  // valid is trusted as a one-cycle pulse from the converter
  always_comb begin
    next_acc = acc;
    if (conv_result_i.valid) begin
      if (burst_mode_enable_i) begin
        if (burst_first_result && !accumulate_enable) begin
          next_acc = conv_result_i.data; // R9
        end else begin
          next_acc = 16'(acc + conv_result_i.data); // R9 R21
        end
      end else if (accumulate_enable) begin
        next_acc = 16'(acc + conv_result_i.data); // R4 R21
      end else begin
        next_acc = conv_result_i.data; // R3
      end
    end
  end

  // a software byte write beats a result landing in the same cycle,
  // so a stray sample in the cycle of a clear byte write cannot undo that write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc <= 16'h0000;
    end else if (sfr_req_i.wr && sel_high) begin
      acc <= {sfr_req_i.wdata, acc[7:0]}; // R5
    end else if (sfr_req_i.wr && sel_low) begin
      acc <= {acc[15:8], sfr_req_i.wdata}; // R5
    end else begin
      acc <= next_acc;
    end
  end

  // ****************************************************************
  // burst sequencing
  // ****************************************************************
  // repeat code to conversion count; reserved codes fall back to one
  // software must leave reserved codes alone, so one is a safe guess
  always_comb begin
    case (burst_repeat_count)
      abp_pkg::RPT_4: repeat_total = 7'h04; // R9
      abp_pkg::RPT_8: repeat_total = 7'h08; // R9
      abp_pkg::RPT_16: repeat_total = 7'h10; // R9
      abp_pkg::RPT_32: repeat_total = 7'h20; // R9
      abp_pkg::RPT_64: repeat_total = 7'h40; // R9
      default: repeat_total = 7'h01; // R9
    endcase
  end

  // a start only opens a burst from idle; later ones are dropped
  assign burst_go = burst_mode_enable_i && soc_i && (state == ST_IDLE);
  // the timer only runs when the converter must wake from sleep
  // with the converter enabled it is already awake, so no delay
  assign timer_start = burst_go && !converter_enable_i; // R15

  abp_powerup_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .start_i(timer_start),
    .units_i(powerup_delay_field), // R16 R17
    .done_o(timer_done)
  );

  // burst state machine; start-of-conversion during a burst is ignored
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (burst_go && converter_enable_i) begin
            state <= ST_START; // R14
          end else if (burst_go) begin
            state <= ST_POWERUP; // R15
          end
        end
        ST_POWERUP: begin
          if (timer_done) begin
            state <= ST_START; // R16
          end
        end
        ST_START: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_result_i.valid) begin
            if (conv_left == 7'h01) begin
              state <= ST_IDLE; // R15
            end else begin
              state <= ST_START;
            end
          end
        end
        // all four two-bit codes are states, so this branch is never taken; it goes idle
        default: state <= ST_IDLE;
      endcase
    end
  end

  // conversions still owed in this burst
  // loaded at the accepted start, so a rewrite mid burst waits
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      conv_left <= 7'h00;
    end else if (burst_go) begin
      conv_left <= repeat_total; // R9
    end else if (state == ST_WAIT && conv_result_i.valid) begin
      conv_left <= conv_left - 7'h01;
    end
  end

  // marks the first result of a burst so it can replace the total
  // reset high so a burst right after reset also starts fresh
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      burst_first_result <= 1'b1;
    end else if (burst_go) begin
      burst_first_result <= 1'b1;
    end else if (conv_result_i.valid) begin
      burst_first_result <= 1'b0;
    end
  end

  // ****************************************************************
  // converter controls
  // ****************************************************************
  // start pulse; outside burst it follows soc gated by converter enable, one cycle later
  // the first flag lets the outside track timer skip its delay
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      convert_start_o <= 1'b0;
      first_conversion_o <= 1'b0;
    end else if (burst_mode_enable_i) begin
      convert_start_o <= (state == ST_START);
      first_conversion_o <= (state == ST_START) &&
                            burst_first_result; // R20
    end else begin
      convert_start_o <= soc_i && converter_enable_i; // R13
      first_conversion_o <= 1'b0;
    end
  end

  // power: enable alone outside burst; in burst also while busy
  // trade-off: power drops the edge after the last result lands
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      converter_power_on_o <= 1'b0;
    end else if (!burst_mode_enable_i) begin
      converter_power_on_o <= converter_enable_i; // R13
    end else begin
      converter_power_on_o <= converter_enable_i || // R14
                              (state != ST_IDLE) || burst_go; // R15
    end
  end

  // busy flag for the surrounding converter logic
  // burst_go lets busy rise on the same edge as the state
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      burst_busy_o <= 1'b0;
    end else begin
      burst_busy_o <= (state != ST_IDLE) || burst_go;
    end
  end

endmodule

// File: bench/abp_core_chk.sv
`timescale 1ns/1ns
// ****************************************************************
// checker on the ports of the core
// ****************************************************************
module abp_core_chk #(
  parameter int UNIT_CYCLES = 40
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire abp_pkg::abp_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic burst_mode_enable_i,
  input wire logic converter_enable_i,
  input wire logic soc_i,
  input wire abp_pkg::abp_result_t conv_result_i,
  input wire logic twelve_bit_enable_o,
  input wire logic converter_low_power_enable_o,
  input wire logic converter_power_on_o,
  input wire logic convert_start_o,
  input wire logic first_conversion_o,
  input wire logic burst_busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic pg0, cfg_sel, pwr_sel, mapped, go, slow;
  logic [3:0] units;
  logic [15:0] cnt;
  int lo_bound;
  // page and address decode of the bus
  assign pg0 = sfr_req_i.page == 8'h00;
  assign cfg_sel = pg0 && sfr_req_i.addr == 8'hba;
  assign pwr_sel = sfr_req_i.page == 8'h0f && sfr_req_i.addr == 8'hba;
  assign mapped = cfg_sel || pwr_sel ||
    (pg0 && (sfr_req_i.addr == 8'hbd || sfr_req_i.addr == 8'hbe));
  assign go = soc_i && burst_mode_enable_i && !burst_busy_o;
  // one less than the delay: the counter lags the sampled start by one
  assign lo_bound = (int'(units) + 1) * UNIT_CYCLES - 1;
  // shadow of the power-up field, needed for the delay bound
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      units <= 4'hf;
    end else if (sfr_req_i.wr && pwr_sel) begin
      units <= sfr_req_i.wdata[3:0];
    end
  end
  // cycles since an accepted burst start, saturating
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt <= 16'hffff;
      slow <= 1'b0;
    end else if (go) begin
      cnt <= 16'h0000;
      slow <= !converter_enable_i;
    end else if (cnt != 16'hffff) begin
      cnt <= cnt + 16'h0001;
    end
  end
  sequence s_fast_go;
    go && converter_enable_i;
  endsequence
  sequence s_first_start;
    convert_start_o && first_conversion_o;
  endsequence
  a_cfg_bit6_zero: assert property (
    sfr_req_i.rd && cfg_sel |=> !sfr_rdata_o[6])
    else $error("config read shows bit six");
  a_pwr_unused_zero: assert property (
    sfr_req_i.rd && pwr_sel |=> sfr_rdata_o[6:4] == 3'h0)
    else $error("power read shows unused bits");
  a_unmapped_read_zero: assert property (
    sfr_req_i.rd && !mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_twelve_bit_write: assert property (
    sfr_req_i.wr && cfg_sel |=>
    twelve_bit_enable_o == $past(sfr_req_i.wdata[7]))
    else $error("twelve bit enable not written");
  a_low_power_write: assert property (
    sfr_req_i.wr && pwr_sel |=>
    converter_low_power_enable_o == $past(sfr_req_i.wdata[7]))
    else $error("low power enable not written");
  a_nonburst_power_follow: assert property (
    !burst_mode_enable_i && !burst_busy_o |=>
    converter_power_on_o == $past(converter_enable_i))
    else $error("power does not follow enable");
  a_burst_fast_start: assert property (
    s_fast_go |-> ##2 s_first_start)
    else $error("fast burst start late");
  a_burst_slow_start: assert property (
    first_conversion_o && slow |-> cnt >= lo_bound && cnt <= lo_bound + 8)
    else $error("power-up delay wrong");
  a_first_with_start: assert property (
    first_conversion_o |-> convert_start_o ##1 !convert_start_o)
    else $error("first flag without start pulse");
  a_burst_powered: assert property (
    burst_busy_o |-> converter_power_on_o)
    else $error("burst busy while unpowered");
endmodule

bind abp_core abp_core_chk #(.UNIT_CYCLES(UNIT_CYCLES)) i_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .burst_mode_enable_i(burst_mode_enable_i),
  .converter_enable_i(converter_enable_i), .soc_i(soc_i),
  .conv_result_i(conv_result_i), .twelve_bit_enable_o(twelve_bit_enable_o),
  .converter_low_power_enable_o(converter_low_power_enable_o),
  .converter_power_on_o(converter_power_on_o),
  .convert_start_o(convert_start_o), .first_conversion_o(first_conversion_o),
  .burst_busy_o(burst_busy_o));

// File: bench/test_abp_core.sv
`timescale 1ns/1ns
module test_abp_core;
  localparam int UNITS = 4; // short power-up unit keeps the run small
  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] data;
    logic [15:0] exp;
  } abp_row_t;
  logic sys_clk_i, srst_i, burst, enable, soc;
  logic twelve, low_pwr, pwr_on, start, first, busy;
  abp_pkg::abp_sfr_req_t req;
  abp_pkg::abp_result_t res;
  logic [7:0] rdata, rb;
  logic [15:0] word;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_start, lat;
  int counts [6] = '{1, 4, 8, 16, 32, 64};
  abp_row_t rows [6] = '{'{8'h80, 16'h0abc, 16'h0abc},
    '{8'h88, 16'h0abc, 16'h055e}, '{8'h90, 16'h0abc, 16'h02af},
    '{8'h98, 16'h0abc, 16'h0157}, '{8'ha0, 16'h0abc, 16'habc0},
    '{8'h20, 16'h02bc, 16'haf00}};

  abp_core #(.UNIT_CYCLES(UNITS)) i_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .burst_mode_enable_i(burst),
    .converter_enable_i(enable), .soc_i(soc), .conv_result_i(res),
    .twelve_bit_enable_o(twelve), .converter_low_power_enable_o(low_pwr),
    .converter_power_on_o(pwr_on), .convert_start_o(start),
    .first_conversion_o(first), .burst_busy_o(busy));

  // ****************************************************************
  // clock, watchdog and shared tasks
  // ****************************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // a hung handshake ends here rather than running forever
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // strobe held one full cycle, then one idle cycle before the next
  task automatic sfr_write(input logic [7:0] pg, ad, d);
    req = '{page: pg, addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk_i);
    req.wr = 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic sfr_read(input logic [7:0] pg, ad, output logic [7:0] d);
    req = '{page: pg, addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk_i);
    req.rd = 1'b0;
    d = rdata;
    @(negedge sys_clk_i);
  endtask
  task automatic read_word(output logic [15:0] w);
    sfr_read(8'h00, 8'hbd, w[7:0]);
    sfr_read(8'h00, 8'hbe, w[15:8]);
  endtask
  task automatic put_result(input logic [15:0] d);
    res = '{valid: 1'b1, data: d};
    @(negedge sys_clk_i);
    res.valid = 1'b0;
    @(negedge sys_clk_i);
  endtask
  // answers every start with a result; lat is cycles from soc to first
  task automatic run_burst(output int starts, output int lat);
    starts = 0;
    lat = 0;
    soc = 1'b1;
    @(negedge sys_clk_i);
    soc = 1'b0;
    for (int t = 1; t < 3000; t++) begin
      if (start) begin
        if (lat == 0) lat = t;
        starts++;
        @(negedge sys_clk_i);
        put_result(16'h0010);
      end else if (!busy && starts > 0) begin
        break;
      end else begin
        @(negedge sys_clk_i);
      end
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {srst_i, burst, enable, soc} = 4'h8;
    req = '0;
    res = '0;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    sfr_read(8'h00, 8'hba, rb);
    check({8'h00, rb}, 16'h0000, "config reset");
    sfr_read(8'h0f, 8'hba, rb);
    check({8'h00, rb}, 16'h000f, "power reset");
    enable = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    check({15'h0, pwr_on}, 16'h0001, "power on");
    soc = 1'b1;
    @(negedge sys_clk_i);
    soc = 1'b0;
    check({15'h0, start}, 16'h0001, "single start");
    // single conversions in every listed format
    foreach (rows[i]) begin
      sfr_write(8'h00, 8'hba, rows[i].cfg);
      put_result(rows[i].data);
      read_word(word);
      check(word, rows[i].exp, "format");
      check({15'h0, twelve}, {15'h0, rows[i].cfg[7]}, "twelve");
      sfr_read(8'h00, 8'hba, rb);
      check({8'h00, rb}, {8'h00, rows[i].cfg}, "config read");
    end
    // accumulate across a wrap, then clear
    sfr_write(8'h00, 8'hba, 8'h40);
    sfr_write(8'h00, 8'hbd, 8'h00);
    sfr_write(8'h00, 8'hbe, 8'h00);
    put_result(16'h8000);
    put_result(16'h9000);
    read_word(word);
    check(word, 16'h1000, "accumulate wrap");
    sfr_read(8'h00, 8'hba, rb);
    check({8'h00, rb}, 16'h0000, "accumulate bit read");
    sfr_write(8'h00, 8'hbd, 8'h00);
    sfr_write(8'h00, 8'hbe, 8'h00);
    read_word(word);
    check(word, 16'h0000, "cleared");
    sfr_read(8'h00, 8'h33, rb);
    check({8'h00, rb}, 16'h0000, "unmapped");
    sfr_write(8'h0f, 8'hba, 8'hff);
    sfr_read(8'h0f, 8'hba, rb);
    check({8'h00, rb}, 16'h008f, "power read");
    check({15'h0, low_pwr}, 16'h0001, "low power");
    enable = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    check({15'h0, pwr_on}, 16'h0000, "power off");
    // burst with converter enabled, every repeat code
    enable = 1'b1;
    burst = 1'b1;
    for (int c = 0; c < 6; c++) begin
      sfr_write(8'h00, 8'hba, 8'(c));
      run_burst(n_start, lat);
      check(16'(n_start), 16'(counts[c]), "repeat");
      check(16'(lat), 16'h0002, "immediate");
      read_word(word);
      check(word, 16'(counts[c] * 16), "burst sum");
    end
    check({15'h0, pwr_on}, 16'h0001, "stays on");
    // burst with converter disabled waits out the power-up delay
    sfr_write(8'h0f, 8'hba, 8'h04);
    check({15'h0, low_pwr}, 16'h0000, "low power off");
    sfr_write(8'h00, 8'hba, 8'h00);
    enable = 1'b0;
    run_burst(n_start, lat);
    check(16'(lat >= 5 * UNITS && lat <= 5 * UNITS + 5), 16'h1, "dly");
    repeat (4) @(negedge sys_clk_i);
    check({15'h0, pwr_on}, 16'h0000, "sleeps");
    tally_and_finish();
  end
endmodule
